// *** logic/wdr_pkg.sv ***
package wdr_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_INDEX  = 8'h21;
  localparam logic [7:0] CAUSE_INDEX = 8'h22;
  localparam logic [7:0] CTRL_ADDR   = 8'(CTRL_INDEX * 4);
  localparam logic [7:0] CAUSE_ADDR  = 8'(CAUSE_INDEX * 4);

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int IRQ_FLAG_BIT   = 7;
  localparam int IRQ_EN_BIT     = 6;
  localparam int SEL_HI_BIT     = 5;
  localparam int CHANGE_EN_BIT  = 4;
  localparam int RESET_EN_BIT   = 3;
  localparam int WD_CAUSE_BIT   = 3;
  localparam int BOD_CAUSE_BIT  = 2;
  localparam int PIN_CAUSE_BIT  = 1;
  localparam int POR_CAUSE_BIT  = 0;

  // ----------------------------------------------------------------
  // Values after reset and counts
  // ----------------------------------------------------------------
  localparam logic [3:0] SEL_RESET      = 4'h0;
  localparam logic [2:0] WINDOW_CYCLES  = 3'h4;
  localparam logic [3:0] SEL_MAX_VALID  = 4'h9;
  localparam int         BASE_LOG2      = 11;
  localparam int         CNT_WIDTH      = 20;
  localparam int         OSC_HZ         = 128000;
  localparam int         CLK_HZ         = 20000000;

endpackage

// *** logic/wdr_tmr_if.sv ***
`timescale 1ns/1ps
// Control side to prescaler counter
interface wdr_tmr_if;
  logic       tick;
  logic       restart;
  logic       run;
  logic [3:0] sel;
  logic       timeout;

  modport ctl (output tick, output restart, output run, output sel, input timeout);
  modport tmr (input tick, input restart, input run, input sel, output timeout);
endinterface

// *** logic/wdr_sync.sv ***
`timescale 1ns/1ps
// Two-flop synchroniser with rising-edge pulse
module wdr_sync (
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic din,
  output logic      rise
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic rise;
  } wdr_sync_t;

  wdr_sync_t q;
  wdr_sync_t next_q;

  // Only the second stage reads the first
  always_comb begin
    next_q      = q;
    next_q.s1   = din;
    next_q.s2   = q.s1;
    next_q.s3   = q.s2;
    next_q.rise = q.s2 & ~q.s3;
    if (reset) begin
      next_q = '0;
    end
  end

  always_ff @(posedge clk) begin
    q <= next_q;
  end

  assign rise = q.rise;
endmodule

// *** logic/wdr_counter.sv ***
`timescale 1ns/1ps
// Prescaler counter on oscillator ticks
module wdr_counter
  import wdr_pkg::*;
#(
  parameter int BASE = BASE_LOG2
) (
  input  wire logic clk,
  input  wire logic reset,
  wdr_tmr_if.tmr    tif
);
  typedef struct packed {
    logic [CNT_WIDTH-1:0] cnt;
    logic                 timeout;
  } wdr_cnt_t;

  wdr_cnt_t             q;
  wdr_cnt_t             next_q;
  logic [3:0]           sel_eff;
  logic [CNT_WIDTH-1:0] term;
  logic [CNT_WIDTH-1:0] one;

  // Reserved codes fall back to the longest valid interval
  assign sel_eff = (tif.sel > SEL_MAX_VALID) ? SEL_MAX_VALID : tif.sel;
  assign one     = CNT_WIDTH'(1);
  assign term    = (one << (BASE + int'(sel_eff))) - one;

  // Count ticks, restart on request, stop or expiry
  always_comb begin
    next_q         = q;
    next_q.timeout = 1'b0;
    if (reset || tif.restart || !tif.run) begin
      next_q.cnt = '0;
    end else if (tif.tick) begin
      if (q.cnt >= term) begin
        next_q.cnt     = '0;
        next_q.timeout = 1'b1;
      end else begin
        next_q.cnt = q.cnt + one;
      end
    end
  end

  always_ff @(posedge clk) begin
    q <= next_q;
  end

  assign tif.timeout = q.timeout;
endmodule

// *** logic/wdr_top.sv ***
`timescale 1ns/1ps
// Watchdog control with reset cause flags
module wdr_top
  import wdr_pkg::*;
#(
  parameter int BASE = BASE_LOG2
) (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        slow_osc,
  input  wire logic        always_on_fuse,
  input  wire logic        restart_instruction,
  input  wire logic        global_irq_enable,
  input  wire logic        irq_vector_taken,
  input  wire logic        poweron_event,
  input  wire logic        pin_reset_event,
  input  wire logic        brownout_event,
  output logic             timeout_irq,
  output logic             sys_reset_req
);
  import wdr_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        waitreq;
    logic [31:0] rdata;
    logic        timeout_irq_flag;
    logic        timeout_irq_enable;
    logic        change_window_enable;
    logic        timeout_reset_enable;
    logic [3:0]  interval_select;
    logic [2:0]  win_cnt;
    logic        fuse;
    logic        watchdog_cause_flag;
    logic        brownout_cause_flag;
    logic        pin_reset_cause_flag;
    logic        poweron_cause_flag;
    logic        irq;
    logic        sysrst;
  } wdr_state_t;

  wdr_state_t q;
  wdr_state_t next_q;

  wdr_tmr_if tif ();

  logic       osc_tick;
  logic       bus_req;
  logic       wr_take;
  logic       wr_ctrl;
  logic       wr_cause;
  logic       chip_rst;
  logic       eff_enable;
  logic [7:0] wd;
  logic [7:0] ctrl_view;
  logic [7:0] cause_view;

  // ----------------------------------------------------------------
  // Oscillator crossing and prescaler counter
  // ----------------------------------------------------------------
  wdr_sync wdr_sync_i (
    .clk   (clk),
    .reset (reset),
    .din   (slow_osc),
    .rise  (osc_tick)
  );

  wdr_counter #(
    .BASE (BASE)
  ) wdr_counter_i (
    .clk   (clk),
    .reset (reset),
    .tif   (tif)
  );

  // Counter runs in any mode except both enables clear
  assign tif.tick    = osc_tick;
  assign tif.run     = eff_enable | q.timeout_irq_enable;
  assign tif.restart = restart_instruction | chip_rst;
  assign tif.sel     = q.interval_select;

  // ----------------------------------------------------------------
  // Decode and views
  // ----------------------------------------------------------------
  // A write takes effect on the edge where waitrequest is low
  assign bus_req  = avs_read | avs_write;
  assign wr_take  = avs_write & ~q.waitreq & avs_byteenable[0];
  assign wr_ctrl  = wr_take & (avs_address == CTRL_ADDR);
  assign wr_cause = wr_take & (avs_address == CAUSE_ADDR);
  assign wd       = avs_writedata[7:0];

  // Any chip reset source, including our own pulse
  assign chip_rst = poweron_event | pin_reset_event | brownout_event | q.sysrst;

  // Level 2 fuse holds the watchdog on
  assign eff_enable = q.timeout_reset_enable | q.fuse;

  // Register images seen by software
  always_comb begin
    ctrl_view                = 8'h00;
    ctrl_view[IRQ_FLAG_BIT]  = q.timeout_irq_flag;
    ctrl_view[IRQ_EN_BIT]    = q.timeout_irq_enable;
    ctrl_view[SEL_HI_BIT]    = q.interval_select[3];
    ctrl_view[CHANGE_EN_BIT] = q.change_window_enable;
    ctrl_view[RESET_EN_BIT]  = eff_enable;
    ctrl_view[2:0]           = q.interval_select[2:0];
  end

  always_comb begin
    cause_view                = 8'h00;
    cause_view[WD_CAUSE_BIT]  = q.watchdog_cause_flag;
    cause_view[BOD_CAUSE_BIT] = q.brownout_cause_flag;
    cause_view[PIN_CAUSE_BIT] = q.pin_reset_cause_flag;
    cause_view[POR_CAUSE_BIT] = q.poweron_cause_flag;
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_q        = q;
    next_q.sysrst = 1'b0;

    // Bus handshake: one wait cycle, then one ready cycle
    if (!q.waitreq) begin
      next_q.waitreq = 1'b1;
    end else if (bus_req) begin
      next_q.waitreq = 1'b0;
      if (avs_read && avs_address == CTRL_ADDR) begin
        next_q.rdata = {24'h000000, ctrl_view};
      end else if (avs_read && avs_address == CAUSE_ADDR) begin
        next_q.rdata = {24'h000000, cause_view};
      end else begin
        next_q.rdata = 32'h00000000;
      end
    end

    // Change window closes on its own after four clocks
    if (q.win_cnt != 3'h0) begin
      next_q.win_cnt = q.win_cnt - 3'h1;
      if (q.win_cnt == 3'h1) begin
        next_q.change_window_enable = 1'b0;
      end
    end

    // Control register write
    if (wr_ctrl) begin
      next_q.timeout_irq_enable = wd[IRQ_EN_BIT];
      if (wd[IRQ_FLAG_BIT]) begin
        next_q.timeout_irq_flag = 1'b0;
      end
      if (wd[RESET_EN_BIT]) begin
        next_q.timeout_reset_enable = 1'b1;
      end else if (q.change_window_enable && !q.watchdog_cause_flag) begin
        next_q.timeout_reset_enable = 1'b0;
      end
      if (q.change_window_enable) begin
        next_q.interval_select = {wd[SEL_HI_BIT], wd[2:0]};
      end
      if (wd[CHANGE_EN_BIT]) begin
        next_q.change_window_enable = 1'b1;
        next_q.win_cnt              = WINDOW_CYCLES;
      end else begin
        next_q.change_window_enable = 1'b0;
        next_q.win_cnt              = 3'h0;
      end
    end

    // Interrupt vector taken acknowledges the flag
    if (irq_vector_taken) begin
      next_q.timeout_irq_flag = 1'b0;
    end

    // Cause register: writing zero clears, writing one keeps
    if (wr_cause) begin
      if (!wd[WD_CAUSE_BIT]) begin
        next_q.watchdog_cause_flag = 1'b0;
      end
      if (!wd[BOD_CAUSE_BIT]) begin
        next_q.brownout_cause_flag = 1'b0;
      end
      if (!wd[PIN_CAUSE_BIT]) begin
        next_q.pin_reset_cause_flag = 1'b0;
      end
      if (!wd[POR_CAUSE_BIT]) begin
        next_q.poweron_cause_flag = 1'b0;
      end
    end

    // Chip reset returns control to its initial values
    if (chip_rst) begin
      next_q.timeout_irq_flag     = 1'b0;
      next_q.timeout_irq_enable   = 1'b0;
      next_q.change_window_enable = 1'b0;
      next_q.timeout_reset_enable = 1'b0;
      next_q.interval_select      = SEL_RESET;
      next_q.win_cnt              = 3'h0;
    end

    // Timeout action by mode; hardware sets win over clears
    if (tif.timeout) begin
      case ({eff_enable, q.timeout_irq_enable})
        2'b01: begin
          next_q.timeout_irq_flag = 1'b1;
        end
        2'b10: begin
          next_q.sysrst              = 1'b1;
          next_q.watchdog_cause_flag = 1'b1;
        end
        2'b11: begin
          next_q.timeout_irq_flag   = 1'b1;
          next_q.timeout_irq_enable = 1'b0;
        end
        default: begin
        end
      endcase
    end

    // Reset sources; power-on clears the other causes first
    if (poweron_event) begin
      next_q.watchdog_cause_flag  = 1'b0;
      next_q.brownout_cause_flag  = 1'b0;
      next_q.pin_reset_cause_flag = 1'b0;
      next_q.poweron_cause_flag   = 1'b1;
    end
    if (pin_reset_event) begin
      next_q.pin_reset_cause_flag = 1'b1;
    end
    if (brownout_event) begin
      next_q.brownout_cause_flag = 1'b1;
    end
    if (next_q.sysrst) begin
      next_q.watchdog_cause_flag = 1'b1;
    end

    // Level 1: watchdog cause holds reset enable on
    if (next_q.watchdog_cause_flag) begin
      next_q.timeout_reset_enable = 1'b1;
    end

    // Level 2: fuse keeps the stored enable too
    if (q.fuse) begin
      next_q.timeout_reset_enable = 1'b1;
    end

    // Interrupt request needs global enable, enable and flag; the enable is
    // taken before a timeout clears it, so the first of two timeouts interrupts
    next_q.irq = next_q.timeout_irq_flag & q.timeout_irq_enable & global_irq_enable;

    // Reset acts as the power-up of the block
    if (reset) begin
      next_q                      = '0;
      next_q.waitreq              = 1'b1;
      next_q.interval_select      = SEL_RESET;
      next_q.poweron_cause_flag   = 1'b1;
      next_q.fuse                 = always_on_fuse;
      next_q.timeout_reset_enable = always_on_fuse;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    q <= next_q;
  end

  // Outputs straight from flops
  assign avs_readdata    = q.rdata;
  assign avs_waitrequest = q.waitreq;
  assign timeout_irq     = q.irq;
  assign sys_reset_req   = q.sysrst;

endmodule

// *** bench/wdr_monitor.sv ***
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Port checks for the watchdog block
// ----------------------------------------------------------------
module wdr_monitor #(
  parameter int BASE = 1
) (
  input wire logic        clk,
  input wire logic        reset,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        global_irq_enable,
  input wire logic        irq_vector_taken,
  input wire logic        timeout_irq,
  input wire logic        sys_reset_req
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  // Request first seen, then a one-cycle answer
  sequence s_req;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_ack;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence

  a_bus_answer: assert property (s_req |=> s_ack) else $error("bus answer not after one wait");
  a_wait_cause: assert property ($fell(avs_waitrequest) |-> $past(avs_read || avs_write))
    else $error("answer without request");
  a_read_upper: assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  a_irq_gate: assert property ($rose(timeout_irq) |-> $past(global_irq_enable))
    else $error("interrupt without global enable");
  a_irq_off: assert property (!global_irq_enable |=> !timeout_irq)
    else $error("interrupt kept with global enable low");
  a_vector_clear: assert property (irq_vector_taken |-> ##2 !timeout_irq)
    else $error("interrupt kept after vector taken");
  a_reset_pulse: assert property (sys_reset_req |=> !sys_reset_req [*3])
    else $error("reset request longer than one cycle");
  a_reset_clears: assert property (sys_reset_req |-> ##2 !timeout_irq)
    else $error("interrupt survives chip reset");
endmodule

bind wdr_top wdr_monitor #(.BASE(BASE)) wdr_monitor_i (
  .clk(clk), .reset(reset), .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .global_irq_enable(global_irq_enable), .irq_vector_taken(irq_vector_taken),
  .timeout_irq(timeout_irq), .sys_reset_req(sys_reset_req)
);

// *** bench/wdr_top_test.sv ***
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Self-checking bench for the watchdog block
// ----------------------------------------------------------------
module wdr_top_test;
  import wdr_pkg::*;
  localparam int TB_BASE = 1;
  logic        clk, reset, avs_read, avs_write, slow_osc, always_on_fuse, osc_en, irq_seen;
  logic        global_irq_enable, timeout_irq, sys_reset_req, avs_waitrequest;
  logic [4:0]  evs;
  logic [1:0]  ph;
  logic [3:0]  sel;
  logic [7:0]  avs_address, rd;
  logic [31:0] avs_writedata, avs_readdata;
  int          n_errors, checks, seed, rises, cyc, n;

  wdr_top #(.BASE(TB_BASE)) wdr_top_i (
    .clk(clk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'h1),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .slow_osc(slow_osc),
    .always_on_fuse(always_on_fuse), .restart_instruction(evs[3]),
    .global_irq_enable(global_irq_enable), .irq_vector_taken(evs[4]),
    .poweron_event(evs[0]), .pin_reset_event(evs[1]), .brownout_event(evs[2]),
    .timeout_irq(timeout_irq), .sys_reset_req(sys_reset_req)
  );

  // Clock
  always #25 clk = ~clk;

  // Slow oscillator while enabled, rise count and hang guard
  always @(posedge clk) begin
    ph <= ph + 2'h1;
    if (osc_en && ph == 2'h3) slow_osc <= ~slow_osc;
    if (osc_en && ph == 2'h3 && !slow_osc) rises <= rises + 1;
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      n_errors++;
      end_sim();
    end
  end

  task chk(input string w, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", w, exp, seen);
    end
  endtask

  // One bus access, held until waitrequest is sampled low
  task bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_write <= wr;
    avs_read <= ~wr;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  task rdc(input string w, input logic [7:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(w, rd, e);
  endtask

  task ev(input logic [4:0] m);
    @(posedge clk);
    evs <= m;
    @(posedge clk);
    evs <= 5'h0;
  endtask

  // Run the oscillator until a reset request (want_rst set) or else an interrupt shows, noting any interrupt
  task wait_out(input logic want_rst);
    rises = 0;
    irq_seen = 1'b0;
    osc_en <= 1'b1;
    do begin
      @(posedge clk);
      if (timeout_irq === 1'b1) irq_seen = 1'b1;
    end while ((want_rst ? sys_reset_req : timeout_irq) !== 1'b1);
    osc_en <= 1'b0;
  endtask

  task do_reset(input logic fuse);
    always_on_fuse <= fuse;
    reset <= 1'b1;
    repeat (12) @(posedge clk);
    reset <= 1'b0;
  endtask

  function automatic logic [7:0] ctl(input logic [3:0] s);
    return {2'b01, s[3], 2'b00, s[2:0]};
  endfunction

  function automatic int span(input logic [3:0] s);
    return 1 << (TB_BASE + ((s > 4'h9) ? 9 : int'(s)));
  endfunction

  task end_sim;
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // Main sequence
  initial begin
    clk = 0; reset = 1; avs_read = 0; avs_write = 0; avs_address = 0; avs_writedata = 0;
    slow_osc = 0; always_on_fuse = 0; osc_en = 0; global_irq_enable = 0; evs = 0; ph = 0;
    n_errors = 0; checks = 0; seed = 44963; rises = 0; cyc = 0;
    do_reset(1'b0);
    rdc("ctrl", CTRL_ADDR, 8'h00);
    rdc("cause", CAUSE_ADDR, 8'h01);
    global_irq_enable <= 1'b1;
    ev(5'h04);
    rdc("cause", CAUSE_ADDR, 8'h05);
    ev(5'h02);
    rdc("cause", CAUSE_ADDR, 8'h07);
    ev(5'h01);
    rdc("cause", CAUSE_ADDR, 8'h01);
    bus(1'b1, CAUSE_ADDR, 8'h00);
    rdc("cause", CAUSE_ADDR, 8'h00);
    $display("test cause flags done");
    for (int i = 0; i < 4; i++) begin
      sel = (i == 0) ? 4'h0 : (i == 3) ? 4'hA : 4'($random(seed)) & 4'h3;
      bus(1'b1, CTRL_ADDR, 8'h18);
      bus(1'b1, CTRL_ADDR, ctl(sel));
      ev(5'h08);
      wait_out(1'b0);
      n = span(sel);
      chk("interval", 8'(rises >= n - 1 && rises <= n + 1), 8'h01);
      rdc("ctrl", CTRL_ADDR, 8'h80 | ctl(sel));
      if (i == 0) ev(5'h10);
      else bus(1'b1, CTRL_ADDR, 8'h80 | ctl(sel));
      rdc("ctrl", CTRL_ADDR, ctl(sel));
      bus(1'b1, CTRL_ADDR, ctl(~sel));
      rdc("ctrl", CTRL_ADDR, ctl(sel));
      bus(1'b1, CTRL_ADDR, 8'h00);
    end
    $display("test intervals done");
    bus(1'b1, CTRL_ADDR, 8'h08);
    wait_out(1'b1);
    chk("irq in reset mode", {7'h0, irq_seen}, 8'h00);
    @(posedge clk);
    chk("reset pulse", {7'h0, sys_reset_req}, 8'h00);
    // The select code accepted last in the loop, sel, still applies here
    n = span(sel);
    chk("reset span", 8'(rises >= n - 1 && rises <= n + 1), 8'h01);
    rdc("cause", CAUSE_ADDR, 8'h08);
    rdc("ctrl", CTRL_ADDR, 8'h08);
    bus(1'b1, CTRL_ADDR, 8'h18);
    bus(1'b1, CTRL_ADDR, 8'h00);
    rdc("ctrl", CTRL_ADDR, 8'h08);
    bus(1'b1, CAUSE_ADDR, 8'h00);
    bus(1'b1, CTRL_ADDR, 8'h18);
    repeat (6) @(posedge clk);
    bus(1'b1, CTRL_ADDR, 8'h00);
    rdc("ctrl", CTRL_ADDR, 8'h08);
    bus(1'b1, CTRL_ADDR, 8'h18);
    bus(1'b1, CTRL_ADDR, 8'h00);
    rdc("ctrl", CTRL_ADDR, 8'h00);
    $display("test reset mode done");
    bus(1'b1, CTRL_ADDR, 8'h48);
    wait_out(1'b1);
    chk("two timeouts", 8'(rises >= 3 && rises <= 5), 8'h01);
    chk("irq first timeout", {7'h0, irq_seen}, 8'h01);
    rdc("cause", CAUSE_ADDR, 8'h08);
    $display("test both enables done");
    do_reset(1'b1);
    rdc("ctrl", CTRL_ADDR, 8'h08);
    bus(1'b1, CTRL_ADDR, 8'h18);
    bus(1'b1, CTRL_ADDR, 8'h00);
    rdc("ctrl", CTRL_ADDR, 8'h08);
    $display("test level two done");
    end_sim();
  end
endmodule
